// ===== src/smhd_top.sv
/*
 * Sampler message header decoder with an AXI4-Lite control slave.
 * Software loads header words and context, writes the request register to
 * start, and reads the decoded fields back. Assumes a single clock.
 */
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module smhd_top (
	input wire logic aclk, // 250 MHz
	input wire logic aresetn, // sync, active low
	input wire logic [7:0] s_awaddr, // write address
	input wire logic s_awvalid, // write address valid
	output logic s_awready, // write address ready
	input wire logic [31:0] s_wdata, // write data
	input wire logic [3:0] s_wstrb, // byte strobes
	input wire logic s_wvalid, // write data valid
	output logic s_wready, // write data ready
	output logic [1:0] s_bresp, // write response
	output logic s_bvalid, // response valid
	input wire logic s_bready, // response ready
	input wire logic [7:0] s_araddr, // read address
	input wire logic s_arvalid, // read address valid
	output logic s_arready, // read address ready
	output logic [31:0] s_rdata, // read data
	output logic [1:0] s_rresp, // read response
	output logic s_rvalid, // read valid
	input wire logic s_rready, // read ready
	output logic done, // decode result valid
	output logic direct_write // scaling result to memory
);
	logic [31:0] d2_q, d3_q, d4_q, csp_q, req_q;
	logic [95:0] res_q;
	wire [95:0] res_d;
	logic done_q, dw_q;
	smhd_pkg::smhd_state_t st_q, st_d;
	logic aw_q, w_q, ar_q;
	logic [7:0] awa_q, ara_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;

	smhd_hdr_if hif ();
	assign hif.d2 = d2_q;
	assign hif.d3 = d3_q;
	assign hif.d4 = d4_q;
	assign hif.cs_ptr = csp_q;
	assign hif.hdr_present = req_q[8];
	assign hif.simd_shared = req_q[9];
	assign hif.zero_resp = req_q[10];
	assign hif.req = smhd_pkg::smhd_req_t'(req_q[3:0]);
	assign hif.fn = smhd_pkg::smhd_fn_t'(req_q[5:4]);

	smhd_field_dec u_dec (
		.h(hif),
		.res(res_d)
	);

	// write channel: capture address and data in either order
	wire wr_go = aw_q && w_q && !s_bvalid;
	wire start = wr_go && awa_q == smhd_pkg::REG_REQ;
	wire wr_ok = awa_q inside {smhd_pkg::REG_D2, smhd_pkg::REG_D3,
		smhd_pkg::REG_D4, smhd_pkg::REG_REQ, smhd_pkg::REG_CSPTR};
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= smhd_pkg::RESET_WORD;
			ws_q <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_q <= 1'b1;
				awa_q <= s_awaddr;
			end else if (wr_go) begin
				aw_q <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_q <= 1'b1;
				wd_q <= s_wdata;
				ws_q <= s_wstrb;
			end else if (wr_go) begin
				w_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= smhd_pkg::RESP_OKAY;
		end else begin
			s_awready <= !aw_q && !(s_awvalid && s_awready);
			s_wready <= !w_q && !(s_wvalid && s_wready);
			if (wr_go) begin
				s_bvalid <= 1'b1;
				s_bresp <= wr_ok ? smhd_pkg::RESP_OKAY : smhd_pkg::RESP_SLVERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			d2_q <= smhd_pkg::RESET_WORD;
			d3_q <= smhd_pkg::RESET_WORD;
			d4_q <= smhd_pkg::RESET_WORD;
			csp_q <= smhd_pkg::RESET_WORD;
			req_q <= smhd_pkg::RESET_WORD;
		// writes during decode are dropped but still answered
		end else if (wr_go && st_q != smhd_pkg::SMHD_DECODE) begin
			case (awa_q)
				smhd_pkg::REG_D2: d2_q <= merge(d2_q, wd_q, ws_q);
				smhd_pkg::REG_D3: d3_q <= merge(d3_q, wd_q, ws_q);
				smhd_pkg::REG_D4: d4_q <= merge(d4_q, wd_q, ws_q);
				smhd_pkg::REG_CSPTR: csp_q <= merge(csp_q, wd_q, ws_q);
				smhd_pkg::REG_REQ: req_q <= merge(req_q, wd_q, ws_q);
				default: req_q <= req_q;
			endcase
		end
	end

	// decode takes one cycle after the request word lands
	always_comb begin
		st_d = st_q;
		case (st_q)
			smhd_pkg::SMHD_IDLE: if (start) st_d = smhd_pkg::SMHD_DECODE;
			smhd_pkg::SMHD_DECODE: st_d = smhd_pkg::SMHD_DONE;
			smhd_pkg::SMHD_DONE: if (start) st_d = smhd_pkg::SMHD_DECODE;
			default: st_d = smhd_pkg::SMHD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= smhd_pkg::SMHD_IDLE;
			res_q <= '0;
			done_q <= 1'b0;
			dw_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (st_q == smhd_pkg::SMHD_DECODE) begin
				res_q <= res_d;
				done_q <= 1'b1;
				dw_q <= res_d[1];
			end else if (start) begin
				done_q <= 1'b0;
			end
		end
	end
	assign done = done_q;
	assign direct_write = dw_q;

	// read channel
	wire [31:0] stat = {29'h0, st_q};
	logic [31:0] rmux;
	logic rok;
	always_comb begin
		rok = 1'b1;
		case (ara_q)
			smhd_pkg::REG_D2: rmux = d2_q;
			smhd_pkg::REG_D3: rmux = d3_q;
			smhd_pkg::REG_D4: rmux = d4_q;
			smhd_pkg::REG_REQ: rmux = req_q;
			smhd_pkg::REG_CSPTR: rmux = csp_q;
			smhd_pkg::REG_RES0: rmux = res_q[95:64];
			smhd_pkg::REG_RES1: rmux = res_q[63:32];
			smhd_pkg::REG_RES2: rmux = res_q[31:0];
			smhd_pkg::REG_STAT: rmux = {stat[31:2], dw_q, done_q};
			default: begin
				rmux = 32'h0000_0000;
				rok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_q <= 1'b0;
			ara_q <= 8'h00;
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= smhd_pkg::RESP_OKAY;
		end else begin
			s_arready <= !ar_q && !s_rvalid && !(s_arvalid && s_arready);
			if (s_arvalid && s_arready) begin
				ar_q <= 1'b1;
				ara_q <= s_araddr;
			end else if (ar_q) begin
				ar_q <= 1'b0;
				s_rvalid <= 1'b1;
				s_rdata <= rmux;
				s_rresp <= rok ? smhd_pkg::RESP_OKAY : smhd_pkg::RESP_SLVERR;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// checks
	sequence decode_seq;
		st_q == smhd_pkg::SMHD_DECODE ##1 done_q;
	endsequence
	start_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
		start && st_q != smhd_pkg::SMHD_DECODE |=> decode_seq)
		else $error("decode did not complete");
	dest_y_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == smhd_pkg::SMHD_DECODE && req_q[8]
		|=> res_q[95:80] == $past(d4_q[31:16]))
		else $error("dest y wrong");
	ssp_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_q == smhd_pkg::SMHD_DECODE && !req_q[8] && req_q[3:0] == 4'h0
		|=> res_q[63:32] == $past(csp_q))
		else $error("pointer not from command stream");
	ssp_align_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_q && req_q[8] |-> res_q[36:32] == 5'h00)
		else $error("pointer misaligned");
	nomask_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_q && !req_q[8] |-> res_q[19:2] == 18'h0_0000)
		else $error("absent header not zero");
	pnm_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_q && req_q[3:0] == 4'h6 |-> !res_q[23])
		else $error("null mask on scaling");
	gch_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_q && !(req_q[3:0] inside {4'h3, 4'h4})
		|-> res_q[19:18] == 2'h0)
		else $error("channel select leaked");
	dw_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_q |-> dw_q == (req_q[3:0] == 4'h6 && req_q[10]))
		else $error("direct write wrong");
	wide_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_q && req_q[3:0] inside {4'h5, 4'h6}
		|-> res_q[13:2] == 12'h000)
		else $error("offsets not ignored");
endmodule : smhd_top
`default_nettype wire

// ===== src/smhd_pkg.sv
/*
 * Constants, types and the control register map of the sampler message
 * header decoder. Assumes one 250 MHz clock, synchronous active-low reset.
 */
// Behaviour
// - destination y position is header dword 4 bits 31:16, unsigned.
// - 32-byte aligned state pointer in dword 3 bits 31:5; not fetch/info.
// - without header, state pointer comes from the command stream input.
// - dword 2 bits 31:24: output target binding index, zero-length replies.
// - dword 2 bit 23 adds pixel null mask phase; ignored for scaling.
// - in shared 8-lane/4x2 mode, dword 2 bit 22 picks 4x2 when set.
// - wide unorm and scaling take output format from dword 2 bits 19:18.
// - scaling: format for adaptive, min/max only; min/max full only.
// - gather requests take sampled channel from dword 2 bits 17:16.
// - dword 2 bits 15..12 mask alpha, blue, green, red writeback.
// - u, v, r offsets are signed 4-bit fields at bits 11:8, 7:4, 3:0.
// - no offsets for wide, scaling; no u, v for per-pixel-offset gather.
// - absent header decodes as all-zero: channels enabled, offsets zero.
// - zero-length scaling response goes straight to memory.
package smhd_pkg;
	localparam int unsigned DESTY_LSB = 16;
	localparam int unsigned DESTX_LSB = 0;
	localparam int unsigned SSP_LSB = 5;
	localparam int unsigned BTI_LSB = 24;
	localparam int unsigned PNM_BIT = 23;
	localparam int unsigned SIMDX_BIT = 22;
	localparam int unsigned OFMT_LSB = 18;
	localparam int unsigned GCH_LSB = 16;
	localparam int unsigned WMASK_LSB = 12;
	localparam int unsigned UOFF_LSB = 8;
	localparam int unsigned VOFF_LSB = 4;
	localparam int unsigned ROFF_LSB = 0;
	// control/status register byte addresses
	localparam logic [7:0] REG_D2 = 8'h00;
	localparam logic [7:0] REG_D3 = 8'h04;
	localparam logic [7:0] REG_D4 = 8'h08;
	localparam logic [7:0] REG_REQ = 8'h0C;
	localparam logic [7:0] REG_CSPTR = 8'h10;
	localparam logic [7:0] REG_RES0 = 8'h14;
	localparam logic [7:0] REG_RES1 = 8'h18;
	localparam logic [7:0] REG_RES2 = 8'h1C;
	localparam logic [7:0] REG_STAT = 8'h20;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// request type codes in REG_REQ bits 3:0
	typedef enum logic [3:0] {
		SMHD_SAMPLE = 4'h0,
		SMHD_FETCH = 4'h1,
		SMHD_RESINFO = 4'h2,
		SMHD_GATHER = 4'h3,
		SMHD_GATHER_PO = 4'h4,
		SMHD_UNORM = 4'h5,
		SMHD_SCALE = 4'h6,
		SMHD_KILLPIX = 4'h7
	} smhd_req_t;
	// scaling function in REG_REQ bits 5:4
	typedef enum logic [1:0] {
		SMHD_FN_ADAPT = 2'h0,
		SMHD_FN_MINMAX = 2'h1,
		SMHD_FN_VIDEO = 2'h2,
		SMHD_FN_OTHER = 2'h3
	} smhd_fn_t;
	localparam logic [1:0] OFMT_16FULL = 2'h0;
	localparam logic [1:0] OFMT_8FULL = 2'h2;
	typedef enum logic [2:0] {
		SMHD_IDLE = 3'h1,
		SMHD_DECODE = 3'h2,
		SMHD_DONE = 3'h4
	} smhd_state_t;
endpackage : smhd_pkg

// ===== src/smhd_hdr_if.sv
/*
 * Carrier of raw header words and request context into the field decoder.
 * Assumes producer and consumer sit on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface smhd_hdr_if;
	logic [31:0] d2;
	logic [31:0] d3;
	logic [31:0] d4;
	logic [31:0] cs_ptr;
	logic hdr_present;
	logic simd_shared;
	logic zero_resp;
	smhd_pkg::smhd_req_t req;
	smhd_pkg::smhd_fn_t fn;
	modport src (output d2, d3, d4, cs_ptr, hdr_present, simd_shared,
		zero_resp, req, fn);
	modport dst (input d2, d3, d4, cs_ptr, hdr_present, simd_shared,
		zero_resp, req, fn);
endinterface : smhd_hdr_if
`default_nettype wire

// ===== src/smhd_field_dec.sv
/*
 * Combinational field decoder for one sampler message header.
 * Assumes inputs are stable registered words from the top module.
 */
`timescale 1ns/1ns
`default_nettype none
module smhd_field_dec (
	smhd_hdr_if.dst h, // header and context
	output logic [95:0] res // packed decoded result
);
	wire [31:0] d2 = h.hdr_present ? h.d2 : smhd_pkg::RESET_WORD;
	wire [31:0] d3 = h.hdr_present ? h.d3 : smhd_pkg::RESET_WORD;
	wire [31:0] d4 = h.hdr_present ? h.d4 : smhd_pkg::RESET_WORD;
	wire is_scale = h.req == smhd_pkg::SMHD_SCALE;
	wire is_wide = is_scale || h.req == smhd_pkg::SMHD_UNORM;
	wire is_gath = h.req == smhd_pkg::SMHD_GATHER ||
		h.req == smhd_pkg::SMHD_GATHER_PO;
	wire no_ssp = h.req == smhd_pkg::SMHD_FETCH ||
		h.req == smhd_pkg::SMHD_RESINFO;
	wire [15:0] dest_y = d4[smhd_pkg::DESTY_LSB +: 16];
	wire [15:0] dest_x = {d4[smhd_pkg::DESTX_LSB + 2 +: 14], 2'h0};
	// pointer kept as byte offset, low five bits forced clear
	wire [31:0] ssp_hdr = {d3[31:smhd_pkg::SSP_LSB], 5'h00};
	wire [31:0] ssp = no_ssp ? 32'h0000_0000 :
		(h.hdr_present ? ssp_hdr : h.cs_ptr);
	wire [7:0] bti = h.zero_resp ? d2[smhd_pkg::BTI_LSB +: 8] : 8'h00;
	wire pnm = d2[smhd_pkg::PNM_BIT] && !is_scale;
	wire four_by_two = h.simd_shared && d2[smhd_pkg::SIMDX_BIT];
	wire [1:0] ofmt_raw = d2[smhd_pkg::OFMT_LSB +: 2];
	wire fmt_used = !is_scale || h.fn == smhd_pkg::SMHD_FN_ADAPT ||
		h.fn == smhd_pkg::SMHD_FN_MINMAX;
	// min/max has no chroma-downsampled forms: fall back to the full one
	wire [1:0] ofmt_mm = {ofmt_raw[1], 1'b0};
	wire [1:0] ofmt = !(is_wide && fmt_used) ? 2'h0 :
		(is_scale && h.fn == smhd_pkg::SMHD_FN_MINMAX) ? ofmt_mm : ofmt_raw;
	wire [1:0] gch = is_gath ? d2[smhd_pkg::GCH_LSB +: 2] : 2'h0;
	wire [3:0] wmask = d2[smhd_pkg::WMASK_LSB +: 4];
	wire uv_off = !is_wide && h.req != smhd_pkg::SMHD_GATHER_PO;
	wire [3:0] uoff = uv_off ? d2[smhd_pkg::UOFF_LSB +: 4] : 4'h0;
	wire [3:0] voff = uv_off ? d2[smhd_pkg::VOFF_LSB +: 4] : 4'h0;
	wire [3:0] roff = is_wide ? 4'h0 : d2[smhd_pkg::ROFF_LSB +: 4];
	wire direct_wr = is_scale && h.zero_resp;
	assign res = {dest_y, dest_x, ssp, bti, pnm, four_by_two, ofmt, gch,
		wmask, uoff, voff, roff, direct_wr, 1'b0};
endmodule : smhd_field_dec
`default_nettype wire

// ===== bench/smhd_thread_model.sv
/*
 * Stand-in for the shader thread: builds header dwords 2..4 for one request.
 * Assumes the bench copies the words into the decoder's header registers.
 */
`timescale 1ns/1ns
`default_nettype none
module smhd_thread_model (
	input wire logic [3:0] req, // request kind
	input wire logic [1:0] fn, // scaling function
	input wire logic [1:0] sel, // variant of the field values
	input wire logic bad, // break the soft rules on command
	output logic [31:0] d2, // header dword 2
	output logic [31:0] d3, // header dword 3
	output logic [31:0] d4 // header dword 4
);
	logic wide;
	logic gat;
	logic pnm;
	logic [3:0] wm;
	logic [1:0] gch;
	logic [11:0] off;
	assign wide = req == smhd_pkg::SMHD_UNORM || req == smhd_pkg::SMHD_SCALE;
	assign gat = req == smhd_pkg::SMHD_GATHER ||
		req == smhd_pkg::SMHD_GATHER_PO;
	// variant 0 stands for a comparison gather on a cube surface
	assign gch = sel;
	// only normalized float coordinates are modelled, so offsets may apply
	assign off = sel == 2'h0 ? 12'h000 : {~sel, 2'h3, 4'h7, 4'h8};
	assign pnm = bad | !(wide || req == smhd_pkg::SMHD_KILLPIX);
	// bit 1 of the mask stays clear for scaling and bit 0 for the rest, so all four are never masked
	assign wm = req == smhd_pkg::SMHD_SCALE ?
		(fn == smhd_pkg::SMHD_FN_VIDEO ? 4'h0 : 4'hD) :
		(gat ? 4'h0 : {sel, 2'h2});
	// reserved bits set on purpose to show they are ignored
	assign d2 = {8'hA4 + 8'(sel), pnm, sel[0], 2'h3, bad ? sel : 2'h0, gch, wm,
		off};
	assign d3 = {16'h0012, 3'h0, sel, 6'h2A, 5'h1F};
	assign d4 = {14'h3000, sel, 12'h010, sel, 2'h0};
endmodule : smhd_thread_model
`default_nettype wire

// ===== bench/testbench.sv
/*
 * Self-checking bench for the sampler message header decoder.
 * Assumes the decoder top's AXI4-Lite register map and hand-over timing.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [31:0] CS = 32'h0ABC_DE00; // aligned stream pointer
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic s_arvalid = 1'b0, s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0;
	logic [3:0] s_wstrb = 4'h0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, done;
	logic direct_write;
	logic [1:0] s_bresp, s_rresp;
	logic [31:0] s_rdata, m_d2, m_d3, m_d4, v;
	logic [3:0] m_req = 4'h0;
	logic [1:0] m_fn = 2'h0, m_sel = 2'h0;
	logic m_bad = 1'b0;
	int n_fail = 0, checked = 0, cyc = 0, i;
	always #2 aclk = ~aclk;
	smhd_top smhd_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .done(done),
		.direct_write(direct_write));
	smhd_thread_model smhd_thread_model_inst (.req(m_req), .fn(m_fn),
		.sel(m_sel), .bad(m_bad), .d2(m_d2), .d3(m_d3), .d4(m_d4));
	task automatic results;
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	// 21 requests of well under 200 cycles each
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			results;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wstrb <= 4'hF;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && s_awready === 1'b1) begin
				s_awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (!wd && s_wready === 1'b1) begin
				s_wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		do @(posedge aclk); while (s_bvalid !== 1'b1);
		s_bready <= 1'b0;
		chk("bresp", {30'h0, e}, {30'h0, s_bresp});
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] e);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge aclk); while (s_arready !== 1'b1);
		s_arvalid <= 1'b0;
		do @(posedge aclk); while (s_rvalid !== 1'b1);
		d = s_rdata;
		s_rready <= 1'b0;
		chk("rresp", {30'h0, e}, {30'h0, s_rresp});
	endtask : rd
	// fl is {zero response length, shared simd, header present}
	task automatic go(input logic [3:0] q, input logic [1:0] f,
		input logic [1:0] s, input logic b, input logic [2:0] fl);
		logic sc, uw, gp, gt, fx;
		logic [1:0] o;
		logic [31:0] h;
		m_req = q;
		m_fn = f;
		m_sel = s;
		m_bad = b;
		#1;
		h = fl[0] ? m_d2 : 32'h0;
		sc = q == smhd_pkg::SMHD_SCALE;
		uw = sc || q == smhd_pkg::SMHD_UNORM;
		gp = q == smhd_pkg::SMHD_GATHER_PO;
		gt = gp || q == smhd_pkg::SMHD_GATHER;
		fx = q == smhd_pkg::SMHD_FETCH || q == smhd_pkg::SMHD_RESINFO;
		o = q == smhd_pkg::SMHD_UNORM ? h[19:18] : 2'h0;
		if (sc && f == smhd_pkg::SMHD_FN_ADAPT) o = h[19:18];
		if (sc && f == smhd_pkg::SMHD_FN_MINMAX) o = {h[19], 1'b0};
		wr(smhd_pkg::REG_D2, m_d2, smhd_pkg::RESP_OKAY);
		wr(smhd_pkg::REG_D3, m_d3, smhd_pkg::RESP_OKAY);
		wr(smhd_pkg::REG_D4, m_d4, smhd_pkg::RESP_OKAY);
		wr(smhd_pkg::REG_CSPTR, CS, smhd_pkg::RESP_OKAY);
		wr(smhd_pkg::REG_REQ, {21'h0, fl, 2'h0, f, q}, smhd_pkg::RESP_OKAY);
		rd(smhd_pkg::REG_STAT, v, smhd_pkg::RESP_OKAY);
		while (v[0] !== 1'b1) rd(smhd_pkg::REG_STAT, v, smhd_pkg::RESP_OKAY);
		chk("stat", {30'h0, sc & fl[2], 1'b1}, {30'h0, v[1:0]});
		chk("ports", {30'h0, sc & fl[2], 1'b1},
			{30'h0, direct_write, done});
		rd(smhd_pkg::REG_RES0, v, smhd_pkg::RESP_OKAY);
		chk("res0", fl[0] ? {m_d4[31:2], 2'h0} : 32'h0, v);
		rd(smhd_pkg::REG_RES1, v, smhd_pkg::RESP_OKAY);
		chk("res1", fx ? 32'h0 : (fl[0] ? {m_d3[31:5], 5'h0} : CS),
			v);
		rd(smhd_pkg::REG_RES2, v, smhd_pkg::RESP_OKAY);
		chk("bti", {24'h0, fl[2] ? h[31:24] : 8'h0}, {24'h0, v[31:24]});
		chk("flags", {30'h0, h[23] & !sc, h[22] & fl[1]},
			{30'h0, v[23:22]});
		chk("fmt", {28'h0, o, gt ? h[17:16] : 2'h0},
			{28'h0, v[21:18]});
		chk("wmask", {28'h0, h[15:12]}, {28'h0, v[17:14]});
		chk("offs", {20'h0, (uw || gp) ? 8'h0 : h[11:4], uw ? 4'h0 : h[3:0]},
			{20'h0, v[13:2]});
		chk("res2 low", {30'h0, sc & fl[2], 1'b0}, {30'h0, v[1:0]});
	endtask : go
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(smhd_pkg::REG_STAT, v, smhd_pkg::RESP_OKAY);
		chk("stat reset", 32'h0, v);
		rd(smhd_pkg::REG_RES2, v, smhd_pkg::RESP_OKAY);
		chk("res2 reset", 32'h0, v);
		for (i = 0; i < 8; i++) begin
			go(4'(i), smhd_pkg::SMHD_FN_ADAPT, 2'(i), 1'b0, {i[0], i[1], 1'b1});
		end
		// all formats, channels and scaling functions; chroma forced on
		for (i = 0; i < 4; i++) begin
			go(smhd_pkg::SMHD_UNORM, smhd_pkg::SMHD_FN_ADAPT, 2'(i), 1'b1, 3'h1);
			go(smhd_pkg::SMHD_GATHER, smhd_pkg::SMHD_FN_ADAPT, 2'(i), 1'b0, 3'h1);
			go(smhd_pkg::SMHD_SCALE, 2'(i), 2'h3, 1'b1, 3'h5);
		end
		go(smhd_pkg::SMHD_SAMPLE, smhd_pkg::SMHD_FN_ADAPT, 2'h1, 1'b0, 3'h6);
		rd(8'h24, v, smhd_pkg::RESP_SLVERR);
		chk("unmapped read", 32'h0, v);
		wr(8'h28, 32'hFFFF_FFFF, smhd_pkg::RESP_SLVERR);
		results;
	end
endmodule : testbench
`default_nettype wire
